/* File: src/slt_pkg.sv */
// shared constants, types and register map of the serial link transmitter
package slt_pkg;
    // register offsets and reset values
    localparam logic [11:0] SLT_REG_LANE_RATE = 12'h056e;
    localparam logic [11:0] SLT_REG_PLL_LOCK  = 12'h056f;
    localparam logic [11:0] SLT_REG_LINK_CTRL = 12'h0571;
    localparam logic [7:0]  SLT_LANE_RATE_RST = 8'h00;
    localparam logic [7:0]  SLT_LINK_CTRL_RST = 8'h03;
    localparam int          SLT_PLL_LOCK_BIT  = 7;
    // link control field positions
    localparam int SLT_CTL_SCR    = 0;
    localparam int SLT_CTL_ALGN   = 1;
    localparam int SLT_CTL_BYPASS = 2;
    localparam int SLT_CTL_INVERT = 3;
    localparam int SLT_CTL_FORMAT = 4;
    // unencoded control characters
    localparam logic [7:0] SLT_CH_R = 8'h1c;  // start of multiframe
    localparam logic [7:0] SLT_CH_A = 8'h7c;  // lane alignment
    localparam logic [7:0] SLT_CH_Q = 8'h9c;  // configuration marker
    localparam logic [7:0] SLT_CH_K = 8'hbc;  // comma
    localparam logic [7:0] SLT_CH_F = 8'hfc;  // frame alignment
    localparam logic [7:0] SLT_SCR_F_MATCH = 8'hfc;
    localparam logic [7:0] SLT_SCR_A_MATCH = 8'hfd;
    // alignment sequence layout
    localparam int          SLT_ILAS_MF   = 4;
    localparam logic [7:0]  SLT_CFG_FIRST = 8'h02;
    localparam int          SLT_CFG_LEN   = 14;
    localparam logic [14:0] SLT_SCR_SEED  = 15'h7fff;
    localparam int          SLT_FIFO_DEPTH = 8;

    // link establishment states, one-hot
    typedef enum logic [3:0] {
        SLT_CGS  = 4'b0001,
        SLT_WAIT = 4'b0010,
        SLT_ILAS = 4'b0100,
        SLT_DATA = 4'b1000
    } slt_state_e;

    // one sample word: one octet for each link
    typedef struct packed {
        logic [7:0] link1;
        logic [7:0] link0;
    } slt_smp_s;

    // software controls steering both links
    typedef struct packed {
        logic fmt_offset;
        logic invert;
        logic bypass;
        logic algn_en;
        logic scr_en;
    } slt_ctrl_s;
endpackage : slt_pkg

/* File: src/slt_top.sv */
// serial link transmitter: fifo, link establishment, 8b/10b, registers
`timescale 1ns/1ps

// small synchronous fifo with valid/ready on both sides
module slt_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,      // system clock
    input  wire logic             rst,       // sync reset, high
    input  wire logic             in_valid,  // write request
    output logic                  in_ready,  // room left
    input  wire logic [WIDTH-1:0] in_data,   // write word
    output logic                  out_valid, // word available
    input  wire logic             out_ready, // read accept
    output logic      [WIDTH-1:0] out_data   // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // honest flags from the occupancy count
    assign in_ready  = cnt_r != (AW+1)'(DEPTH);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem_r[rp_r];

    // storage array, no reset needed
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : slt_fifo

// one link: establishment sequence, alignment characters, scrambler, encoder
module slt_link #(
    parameter int         F_OCT  = 2,   // octets per frame
    parameter int         K_FRM  = 32,  // frames per multiframe
    parameter logic [7:0] DEV_ID = 8'h5a, // arbitrary device id
    parameter logic [4:0] LANE   = 5'h00  // lane id in configuration
) (
    input  wire logic              mclk,      // system clock
    input  wire logic              rst,       // sync reset, high
    input  wire logic              sync_n,    // synchronised request, low
    input  wire slt_pkg::slt_ctrl_s ctrl,     // software controls
    input  wire logic              oct_valid, // user octet available
    output logic                   oct_ready, // user octet taken
    input  wire logic [7:0]        oct_data,  // user octet
    output logic [9:0]             sym,       // encoded lane symbol
    output slt_pkg::slt_state_e    state      // establishment phase
);
    import slt_pkg::*;

    localparam int OW = (F_OCT > 1) ? $clog2(F_OCT) : 1;
    localparam int FW = $clog2(K_FRM);
    localparam logic [191:0] T6 = {
        6'b101011, 6'b011110, 6'b101110, 6'b001110,
        6'b110110, 6'b010110, 6'b100110, 6'b110011,
        6'b111010, 6'b011010, 6'b101010, 6'b001011,
        6'b110010, 6'b010011, 6'b100011, 6'b011011,
        6'b010111, 6'b011100, 6'b101100, 6'b001101,
        6'b110100, 6'b010101, 6'b100101, 6'b111001,
        6'b111000, 6'b011001, 6'b101001, 6'b110101,
        6'b110001, 6'b101101, 6'b011101, 6'b100111};
    localparam logic [31:0] T4 = {
        4'b1110, 4'b0110, 4'b1010, 4'b1101,
        4'b1100, 4'b0101, 4'b1001, 4'b1011};
    localparam logic [31:0] T4K = {
        4'b1000, 4'b0110, 4'b1010, 4'b0010,
        4'b0011, 4'b0101, 4'b1001, 4'b0100};

    // 8b/10b encode; returns {new running disparity, abcdei fghj}
    function automatic logic [10:0] enc(input logic [7:0] b,
                                        input logic k, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic       rd6;
        logic [9:0] s;
        logic       alt;
        s6  = T6[6*b[4:0] +: 6];
        s4  = T4[4*b[7:5] +: 4];
        rd6 = rd;
        s   = '0;
        alt = 1'b0;
        if (k) begin
            s = {6'b001111, T4K[4*b[7:5] +: 4]};
            s = rd ? ~s : s;
        end else begin
            if (rd && (($countones(s6) != 3) || b[4:0] == 5'd7)) begin
                s6 = ~s6;
            end
            rd6 = rd ^ ($countones(s6) != 3);
            alt = (!rd6 && (b[4:0] == 5'd17 || b[4:0] == 5'd18 ||
                            b[4:0] == 5'd20)) ||
                  (rd6 && (b[4:0] == 5'd11 || b[4:0] == 5'd13 ||
                           b[4:0] == 5'd14));
            if (b[7:5] == 3'd7 && alt) begin
                s4 = 4'b0111;
            end
            if (rd6 && (($countones(s4) != 2) || b[7:5] == 3'd3)) begin
                s4 = ~s4;
            end
            s = {s6, s4};
        end
        return {rd ^ ($countones(s) != 5), s};
    endfunction : enc

    // self-synchronising 1 + x^14 + x^15, msb first; {state, octet}
    function automatic logic [22:0] scramble(input logic [7:0] d,
                                             input logic [14:0] st);
        logic [14:0] s;
        logic [7:0]  o;
        s = st;
        o = '0;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ s[14] ^ s[13];
            s    = {s[13:0], o[i]};
        end
        return {s, o};
    endfunction : scramble

    // link configuration octets, checksum in the last one
    function automatic logic [7:0] cfg_octet(input logic [3:0] idx,
                                             input logic scr);
        logic [7:0] c [SLT_CFG_LEN];
        logic [7:0] sum;
        sum   = '0;
        c[0]  = DEV_ID;
        c[1]  = 8'h00;
        c[2]  = {3'b000, LANE};
        c[3]  = {scr, 7'h00};
        c[4]  = 8'(F_OCT - 1);
        c[5]  = 8'(K_FRM - 1);
        c[6]  = 8'h00;
        c[7]  = 8'h07;
        c[8]  = 8'h27;
        c[9]  = 8'h20;
        c[10] = 8'h00;
        c[11] = 8'h00;
        c[12] = 8'h00;
        for (int i = 0; i < SLT_CFG_LEN - 1; i++) begin
            sum = sum + c[i];
        end
        c[13] = sum;
        return c[idx];
    endfunction : cfg_octet

    slt_state_e     state_r;
    slt_state_e     state_nxt;
    logic [OW-1:0]  oct_r;
    logic [FW-1:0]  frm_r;
    logic [1:0]     mf_r;
    logic [7:0]     ramp_r;
    logic [14:0]    scr_r;
    logic [7:0]     prev_r;
    logic           rd_r;
    logic [9:0]     sym_r;

    // frame and multiframe position, free running like the local lmfc
    wire         f_end  = oct_r == OW'(F_OCT - 1);
    wire         mf_end = f_end && frm_r == FW'(K_FRM - 1);
    wire         mf_beg = oct_r == '0 && frm_r == '0;
    wire [7:0]   pos    = 8'(frm_r * F_OCT) + 8'(oct_r);
    wire         in_cfg = mf_r == 2'd1 && pos >= SLT_CFG_FIRST &&
                          pos < SLT_CFG_FIRST + 8'(SLT_CFG_LEN);
    wire [3:0]   cfg_ix = 4'(pos - SLT_CFG_FIRST);
    wire         is_data = state_r == SLT_DATA;

    // user data path: format, scramble, alignment candidates
    wire [7:0]   usr     = oct_valid ? oct_data : 8'h00;
    wire [7:0]   usr_fmt = {usr[7] ^ ctrl.fmt_offset, usr[6:0]};
    wire [22:0]  scr_res = scramble(usr_fmt, scr_r);
    wire [7:0]   scr_oct = scr_res[7:0];
    wire         rep_a_s = ctrl.scr_en && mf_end &&
                           scr_oct == SLT_SCR_A_MATCH;
    wire         rep_f_s = ctrl.scr_en && f_end &&
                           scr_oct == SLT_SCR_F_MATCH;
    wire         rep_u   = !ctrl.scr_en && f_end &&
                           usr_fmt == prev_r;
    wire         rep_a   = ctrl.algn_en &&
                           (rep_a_s || (rep_u && mf_end));
    wire         rep_f   = ctrl.algn_en && !rep_a &&
                           (rep_f_s || rep_u);

    // character chosen for this octet slot
    logic [7:0] ch;
    logic       ch_k;
    always_comb begin
        ch   = SLT_CH_K;
        ch_k = 1'b1;
        if (state_r == SLT_ILAS) begin
            ch_k = 1'b0;
            ch   = ramp_r;
            if (mf_beg) begin
                ch   = SLT_CH_R;
                ch_k = 1'b1;
            end else if (mf_end) begin
                ch   = SLT_CH_A;
                ch_k = 1'b1;
            end else if (mf_r == 2'd1 && pos == 8'd1) begin
                ch   = SLT_CH_Q;
                ch_k = 1'b1;
            end else if (in_cfg) begin
                ch   = cfg_octet(cfg_ix, ctrl.scr_en);
            end
        end else if (is_data) begin
            ch_k = rep_a || rep_f;
            ch   = rep_a ? SLT_CH_A : rep_f ? SLT_CH_F :
                   ctrl.scr_en ? scr_oct : usr_fmt;
        end
    end

    // establishment sequence; a fresh request always wins
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SLT_CGS:  if (sync_n) state_nxt = SLT_WAIT;
            SLT_WAIT: if (mf_end) state_nxt = SLT_ILAS;
            SLT_ILAS: if (mf_end && mf_r == 2'(SLT_ILAS_MF - 1))
                          state_nxt = SLT_DATA;
            SLT_DATA: state_nxt = SLT_DATA;
        endcase
        if (!sync_n) begin
            state_nxt = SLT_CGS;
        end
    end

    // encoded symbol, with debug bypass and inversion
    wire [10:0] enc_res = enc(ch, ch_k, rd_r);
    wire [9:0]  sym_raw = ctrl.bypass ? {2'b00, ch} : enc_res[9:0];
    wire [9:0]  sym_out = ctrl.invert ? ~sym_raw : sym_raw;

    assign oct_ready = is_data;
    assign sym       = sym_r;
    assign state     = state_r;

    // position counters and state
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= SLT_CGS;
            oct_r   <= '0;
            frm_r   <= '0;
            mf_r    <= '0;
        end else begin
            state_r <= state_nxt;
            oct_r   <= f_end ? '0 : oct_r + 1'b1;
            if (f_end) begin
                frm_r <= mf_end ? '0 : frm_r + 1'b1;
            end
            if (state_r != SLT_ILAS) begin
                mf_r <= '0;
            end else if (mf_end) begin
                mf_r <= mf_r + 1'b1;
            end
        end
    end

    // ramp, scrambler, previous frame octet, disparity, symbol
    always_ff @(posedge mclk) begin
        if (rst) begin
            ramp_r <= '0;
            scr_r  <= SLT_SCR_SEED;
            prev_r <= '0;
            rd_r   <= 1'b0;
            sym_r  <= '0;
        end else begin
            ramp_r <= (state_r == SLT_ILAS) ? ramp_r + 1'b1 : 8'h00;
            if (is_data) begin
                scr_r <= scr_res[22:8];
            end
            if (is_data && f_end) begin
                prev_r <= usr_fmt;
            end
            if (!ctrl.bypass) begin
                rd_r <= enc_res[10];
            end
            sym_r <= sym_out;
        end
    end
endmodule : slt_link

module slt_top #(
    parameter int F_OCT = 2,   // octets per frame
    parameter int K_FRM = 32   // frames per multiframe
) (
    input  wire logic             mclk,              // 20 MHz clock
    input  wire logic             rst,               // sync reset, high
    input  wire logic             sync_request_link0, // pin, low = request
    input  wire logic             sync_request_link1, // pin, low = request
    input  wire logic             pll_locked,        // pin from serializer pll
    input  wire logic             smp_valid,         // sample word valid
    output logic                  smp_ready,         // fifo room
    input  wire slt_pkg::slt_smp_s smp_data,         // one octet per link
    input  wire logic [11:0]      reg_addr,          // register address
    input  wire logic             reg_wr,            // write strobe
    input  wire logic [7:0]       reg_wdata,         // write data
    output logic [7:0]            reg_rdata,         // read data, next cycle
    output logic [9:0]            lane_sym0,         // link 0 symbol
    output logic [9:0]            lane_sym1,         // link 1 symbol
    output slt_pkg::slt_state_e   link0_state,       // link 0 phase
    output slt_pkg::slt_state_e   link1_state        // link 1 phase
);
    import slt_pkg::*;

    logic [1:0] sync_a_r;
    logic [1:0] sync_b_r;
    logic [1:0] sync_c_r;
    logic [1:0] lock_a_r;
    logic [7:0] lane_rate_r;
    logic [7:0] ctl_r;
    logic [7:0] rdata_r;
    logic [1:0] f_in_ready;
    logic [1:0] f_valid;
    logic [1:0] f_ready;
    logic [7:0] f_data [2];
    logic [9:0] syms [2];
    slt_state_e states [2];

    // pins cross in through two flops; the first stage feeds nothing else
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_a_r <= 2'b00;
            sync_b_r <= 2'b00;
            lock_a_r <= 2'b00;
        end else begin
            sync_a_r <= {sync_request_link1, sync_request_link0};
            sync_b_r <= sync_a_r;
            lock_a_r <= {lock_a_r[0], pll_locked};
        end
    end
    assign sync_c_r = sync_b_r;

    // control decode; reserved bits read back as zero
    wire        wr_rate = reg_wr && reg_addr == SLT_REG_LANE_RATE;
    wire        wr_ctl  = reg_wr && reg_addr == SLT_REG_LINK_CTRL;
    slt_ctrl_s  ctrl;
    assign ctrl.scr_en     = ctl_r[SLT_CTL_SCR];
    assign ctrl.algn_en    = ctl_r[SLT_CTL_ALGN];
    assign ctrl.bypass     = ctl_r[SLT_CTL_BYPASS];
    assign ctrl.invert     = ctl_r[SLT_CTL_INVERT];
    assign ctrl.fmt_offset = ctl_r[SLT_CTL_FORMAT];
    wire [7:0]  lock_rd = {lock_a_r[1], 7'h00};
    wire [7:0]  rd_mux  =
        (reg_addr == SLT_REG_LANE_RATE) ? lane_rate_r :
        (reg_addr == SLT_REG_PLL_LOCK)  ? lock_rd :
        (reg_addr == SLT_REG_LINK_CTRL) ? {3'b000, ctl_r[4:0]} : 8'h00;

    // registers; the lock register ignores writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            lane_rate_r <= SLT_LANE_RATE_RST;
            ctl_r       <= SLT_LINK_CTRL_RST;
            rdata_r     <= 8'h00;
        end else begin
            if (wr_rate) begin
                lane_rate_r <= reg_wdata;
            end
            if (wr_ctl) begin
                ctl_r <= {3'b000, reg_wdata[4:0]};
            end
            rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = rdata_r;

    // both fifos take a word together so the links stay in step
    assign smp_ready = &f_in_ready;

    for (genvar g = 0; g < 2; g++) begin : g_link
        slt_fifo #(
            .WIDTH (8),
            .DEPTH (SLT_FIFO_DEPTH)
        ) u_fifo (
            .mclk      (mclk),
            .rst       (rst),
            .in_valid  (smp_valid && smp_ready),
            .in_ready  (f_in_ready[g]),
            .in_data   (g == 0 ? smp_data.link0 : smp_data.link1),
            .out_valid (f_valid[g]),
            .out_ready (f_ready[g]),
            .out_data  (f_data[g])
        );
        // receiver honours the four-comma minimum before release
        slt_link #(
            .F_OCT  (F_OCT),
            .K_FRM  (K_FRM),
            .LANE   (5'(g))
        ) u_link (
            .mclk      (mclk),
            .rst       (rst),
            .sync_n    (sync_c_r[g]),
            .ctrl      (ctrl),
            .oct_valid (f_valid[g]),
            .oct_ready (f_ready[g]),
            .oct_data  (f_data[g]),
            .sym       (syms[g]),
            .state     (states[g])
        );
    end

    assign lane_sym0   = syms[0];
    assign lane_sym1   = syms[1];
    assign link0_state = states[0];
    assign link1_state = states[1];
endmodule : slt_top

/* File: dv/slt_rx_model.sv */
// receiver-side model: sync request held until commas are seen
`timescale 1ns/1ps
module slt_rx_model (
    input  wire logic       mclk,   // system clock
    input  wire logic       rst,    // sync reset, high
    input  wire logic       hold,   // bench keeps or raises a request
    input  wire logic [9:0] sym,    // lane symbol seen
    output logic            sync_n  // request pin, low
);
    logic [2:0] k_cnt_r;
    logic       is_k;
    // either disparity, or the raw octet when the encoder is bypassed
    assign is_k = sym inside {10'h0fa, 10'h305, 10'h0bc};
    // release only after four good commas in a row, a slow answer via hold
    always_ff @(posedge mclk) begin
        if (rst || hold) begin
            k_cnt_r <= '0;
            sync_n  <= 1'b0;
        end else if (!sync_n) begin
            k_cnt_r <= is_k ? k_cnt_r + 1'b1 : '0;
            sync_n  <= is_k && k_cnt_r >= 3'd3;
        end
    end
endmodule : slt_rx_model

/* File: dv/slt_top_checker.sv */
// port assertions for the serial link transmitter
`timescale 1ns/1ps
module slt_top_checker #(
    parameter int F_OCT = 2,  // octets per frame
    parameter int K_FRM = 32  // frames per multiframe
) (
    input wire logic                mclk,               // clock
    input wire logic                rst,                // reset
    input wire logic                sync_request_link0, // request
    input wire logic                pll_locked,         // lock pin
    input wire logic [11:0]         reg_addr,           // address
    input wire logic [7:0]          reg_rdata,          // read data
    input wire logic [9:0]          lane_sym0,          // symbol
    input wire slt_pkg::slt_state_e link0_state         // phase
);
    import slt_pkg::*;
    localparam int MF = F_OCT * K_FRM;
    logic [15:0] pos_r;
    logic [15:0] ilas_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // multiframe position from release, and cycles spent aligning
    always_ff @(posedge mclk) begin
        pos_r  <= (rst || pos_r == MF - 1) ? '0 : pos_r + 1'b1;
        ilas_r <= (rst || link0_state != SLT_ILAS) ? '0 : ilas_r + 1'b1;
    end
    a_phase_valid: assert property (
        link0_state inside {SLT_CGS, SLT_WAIT, SLT_ILAS, SLT_DATA})
        else $error("phase code invalid");
    a_cgs_comma: assert property (
        link0_state == SLT_CGS
            |=> lane_sym0 inside {10'h0fa, 10'h305, 10'h0bc})
        else $error("no comma in sync phase");
    a_req_to_cgs: assert property (
        !sync_request_link0 [*4] |=> link0_state == SLT_CGS)
        else $error("request did not force sync phase");
    a_lmfc_start: assert property (
        $rose(link0_state == SLT_ILAS) |-> pos_r == 0
            && $past(link0_state) == SLT_WAIT)
        else $error("alignment off the multiframe boundary");
    a_mf_start: assert property (
        link0_state == SLT_ILAS && ilas_r % MF == 0
            |=> lane_sym0 inside {10'h0f4, 10'h30b, 10'h01c})
        else $error("multiframe start character missing");
    a_mf_end: assert property (
        link0_state == SLT_ILAS && ilas_r % MF == MF - 1
            |=> lane_sym0 inside {10'h0f3, 10'h30c, 10'h07c})
        else $error("multiframe end character missing");
    a_cfg_marker: assert property (
        link0_state == SLT_ILAS && ilas_r == MF + 1
            |=> lane_sym0 inside {10'h0f2, 10'h0f4, 10'h30d, 10'h09c})
        else $error("configuration marker missing");
    a_ilas_length: assert property (
        $fell(link0_state == SLT_ILAS)
            |-> link0_state == SLT_DATA && ilas_r == 4 * MF)
        else $error("alignment length wrong");
    a_lock_read: assert property (
        $stable(pll_locked) [*4] ##0 reg_addr == SLT_REG_PLL_LOCK
            |=> reg_rdata[SLT_PLL_LOCK_BIT] == $past(pll_locked))
        else $error("lock flag does not follow pin");
endmodule : slt_top_checker
bind slt_top slt_top_checker #(.F_OCT(F_OCT), .K_FRM(K_FRM)) u_chk (
    .mclk(mclk), .rst(rst), .sync_request_link0(sync_request_link0),
    .pll_locked(pll_locked), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .lane_sym0(lane_sym0), .link0_state(link0_state));

/* File: dv/slt_top_tb.sv */
// self-checking bench for the serial link transmitter
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
miscompares++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module slt_top_tb;
    import slt_pkg::*;
    localparam int F = 2;
    localparam int K = 16;
    localparam int MF = F * K;
    int          seed = 80354;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          n;
    int          i;
    logic        mclk = 0, rst = 1, hold = 1, pll = 0, vld = 0, wr_en = 0;
    logic        sync0, sync1, rdy;
    logic [11:0] addr = '0;
    logic [7:0]  wdata = '0, rdata, d0, d1, prev0 = '0, prev1 = '0;
    logic [8:0]  ex0, ex1;
    logic [9:0]  sym0, sym1;
    slt_smp_s    smp = '0;
    slt_smp_s    w [8];
    slt_state_e  st0, st1;
    slt_top #(.F_OCT(F), .K_FRM(K)) dut (.mclk(mclk), .rst(rst),
        .sync_request_link0(sync0), .sync_request_link1(sync1),
        .pll_locked(pll), .smp_valid(vld), .smp_ready(rdy), .smp_data(smp),
        .reg_addr(addr), .reg_wr(wr_en), .reg_wdata(wdata), .reg_rdata(rdata),
        .lane_sym0(sym0), .lane_sym1(sym1), .link0_state(st0),
        .link1_state(st1));
    slt_rx_model rx0 (.mclk(mclk), .rst(rst), .hold(hold), .sym(sym0),
        .sync_n(sync0));
    slt_rx_model rx1 (.mclk(mclk), .rst(rst), .hold(hold), .sym(sym1),
        .sync_n(sync1));
    // free-running 20 MHz clock
    initial forever #25 mclk = ~mclk;
    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk);
        addr = a;
        wr_en = 1;
        wdata = d;
        @(negedge mclk);
        wr_en = 0;
    endtask : wr
    // read data arrives one cycle after the address
    task automatic rd(input logic [11:0] a, input logic [7:0] ex,
                      input logic [7:0] m);
        @(negedge mclk);
        addr = a;
        @(negedge mclk);
        `CHK("register", ex, rdata & m)
    endtask : rd
    // bounded wait for a link phase
    task automatic wait_phase(input slt_state_e s);
        for (i = 0; i < 400 && st0 !== s; i++) @(negedge mclk);
    endtask : wait_phase
    // octet expected at index n from alignment start; bit 8 = compared
    function automatic logic [8:0] expect_oct(input int n,
        input logic [7:0] d, inout logic [7:0] prev);
        int p;
        p = n % MF;
        expect_oct = {n / MF != 1 || p > 15, n[7:0]};
        if (p == 0) expect_oct = {1'b1, SLT_CH_R};
        if (n / MF == 1 && p == 1) expect_oct = {1'b1, SLT_CH_Q};
        if (p == MF - 1) expect_oct = {1'b1, SLT_CH_A};
        if (n >= 4 * MF) begin
            expect_oct = {n != 4 * MF + F - 1, d};
            if (p % F == F - 1 && d == prev)
                expect_oct[7:0] = (p == MF - 1) ? SLT_CH_A : SLT_CH_F;
            if (p % F == F - 1) prev = d;
        end
    endfunction : expect_oct
    // hang guard, well beyond the few hundred cycles the run needs
    initial begin
        repeat (3000) @(posedge mclk);
        miscompares++;
        summarize();
    end
    initial begin
        pll = 1'($random(seed));
        for (i = 0; i < 8; i++) w[i] = slt_smp_s'($random(seed));
        w[3].link0 = w[1].link0; // repeated frame-end octet
        w[5].link1 = w[3].link1;
        repeat (10) @(negedge mclk);
        rst = 0;
        rd(SLT_REG_LANE_RATE, SLT_LANE_RATE_RST, 8'hff);
        rd(SLT_REG_LINK_CTRL, SLT_LINK_CTRL_RST, 8'hff);
        rd(SLT_REG_PLL_LOCK, {pll, 7'h00}, 8'h80);
        rd(12'h0123, 8'h00, 8'hff);
        wr(SLT_REG_LANE_RATE, 8'h10);
        rd(SLT_REG_LANE_RATE, 8'h10, 8'hff);
        wr(SLT_REG_PLL_LOCK, {~pll, 7'h00});
        rd(SLT_REG_PLL_LOCK, {pll, 7'h00}, 8'h80);
        // invert stays off while commas are checked on the lane
        wr(SLT_REG_LINK_CTRL, 8'hf7);
        rd(SLT_REG_LINK_CTRL, 8'h17, 8'hff);
        wr(SLT_REG_LINK_CTRL, 8'h16); // raw octets, offset format
        repeat (2) @(negedge mclk);
        `CHK("comma", {2'b00, SLT_CH_K}, sym1)
        $display("test registers done");
        // fill both fifos while the links still wait for sync
        n = 0;
        repeat (12) begin
            @(negedge mclk);
            vld = rdy;
            smp = w[n % 8];
            n += int'(rdy);
        end
        @(negedge mclk);
        vld = 0;
        `CHK("fifo fill", 8, n)
        `CHK("fifo full", 1'b0, rdy)
        hold = 0;
        wait_phase(SLT_ILAS);
        for (n = 0; n < 5 * MF; n++) begin
            i = n - 4 * MF;
            d0 = ((i >= 0 && i < 8) ? w[i].link0 : 8'h00) ^ 8'h80;
            d1 = ((i >= 0 && i < 8) ? w[i].link1 : 8'h00) ^ 8'h80;
            @(negedge mclk);
            ex0 = expect_oct(n, d0, prev0);
            ex1 = expect_oct(n, d1, prev1);
            if (ex0[8]) `CHK("lane0", {2'b00, ex0[7:0]}, sym0)
            if (ex1[8]) `CHK("lane1", {2'b00, ex1[7:0]}, sym1)
        end
        $display("test alignment and data done");
        // inversion flips the two padding bits of a raw octet
        wr(SLT_REG_LINK_CTRL, 8'h1e);
        repeat (2) @(negedge mclk);
        `CHK("invert", 2'b11, sym1[9:8])
        // request again mid data, then relink encoded and scrambled
        wr(SLT_REG_LINK_CTRL, SLT_LINK_CTRL_RST);
        hold = 1;
        repeat (6) @(negedge mclk);
        `CHK("resync", SLT_CGS, st1)
        hold = 0;
        wait_phase(SLT_DATA);
        `CHK("relink", SLT_DATA, st1)
        $display("test resync done");
        summarize();
    end
endmodule : slt_top_tb
